// [hw/negotiation_status_pkg.sv]
// Constants shared by the next-page status register bank and its helpers.
package negotiation_status_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the management port.
    localparam logic [3:0] OFS_PAGE_WORD = 4'h0;
    localparam logic [3:0] OFS_EXPANSION = 4'h1;
    localparam logic [3:0] OFS_EVT_STATUS = 4'h2;
    localparam logic [3:0] OFS_EVT_MASK = 4'h3;
    localparam logic [3:0] OFS_PAGE_COUNT = 4'h4;

    ////////////////////////////////////////////////////////////////////////
    // Received next page word fields.
    localparam int BIT_MORE_PAGES = 15;
    localparam int BIT_PARTNER_ACK = 14;
    localparam int BIT_MSG_PAGE = 13;
    localparam int BIT_COMPLY = 12;
    localparam int BIT_TOGGLE = 11;
    localparam int CODE_MSB = 10;
    localparam int CODE_LSB = 0;
    localparam logic [15:0] PAGE_WORD_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Expansion register fields.
    localparam int EXP_RSVD_MSB = 15;
    localparam int EXP_RSVD_LSB = 5;
    localparam int BIT_FAULT = 4;
    localparam int BIT_PARTNER_MULTI = 3;
    localparam int BIT_LOCAL_MULTI = 2;
    localparam int BIT_PAGE_RX = 1;
    localparam int BIT_PARTNER_NEG = 0;
    localparam logic LOCAL_MULTI_VALUE = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Event status and mask layout.
    localparam int EVT_W = 4;
    localparam int EVT_PAGE = 0;
    localparam int EVT_FAULT = 1;
    localparam int EVT_OVERRUN = 2;
    localparam int EVT_PARTNER_MULTI = 3;
    localparam logic [3:0] EVT_MASK_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser depth and page counter reset.
    localparam int SYNC_STAGES = 3;
    localparam logic [15:0] PAGE_COUNT_RST = 16'h0000;

endpackage : negotiation_status_pkg

// [hw/pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous level inputs.
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            logic [negotiation_status_pkg::SYNC_STAGES-1:0] stage_reg;
            logic level_reg;
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    stage_reg <= '0;
                end else if (ce_i) begin
                    stage_reg <= {stage_reg[negotiation_status_pkg::SYNC_STAGES-2:0], async_i[g]};
                end
            end
            // A change counts only once the second and third stages agree.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    level_reg <= 1'b0;
                end else if (ce_i && (stage_reg[1] == stage_reg[2])) begin
                    level_reg <= stage_reg[2];
                end
            end
            assign level_o[g] = level_reg;
        end
    endgenerate

endmodule : pin_sync

// [hw/event_bank.sv]
// Sticky event flags, write-one-to-clear, with masked level interrupt.
`timescale 1ns/10ps
module event_bank #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Events and software clear
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    input wire logic [W-1:0] mask_i,
    // Results
    output logic [W-1:0] status_o,
    output logic irq_o
);

    logic [W-1:0] status_reg;
    logic irq_reg;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_flag
            // A set in the same cycle as its clear wins so no event is lost.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    status_reg[g] <= 1'b0;
                end else if (ce_i) begin
                    if (set_i[g]) begin
                        status_reg[g] <= 1'b1;
                    end else if (clr_i[g]) begin
                        status_reg[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else if (ce_i) begin
            irq_reg <= |(status_reg & mask_i);
        end
    end

    assign status_o = status_reg;
    assign irq_o = irq_reg;

endmodule : event_bank

// [hw/autoneg_next_page_status_regs.sv]
// Received next page word and negotiation expansion status registers.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Bit 13 of the received page word is the message page flag, telling formatted from unformatted code.
// - Bit 12 is the read-only partner comply flag, reset to 0.
// - Bit 11 is the read-only partner toggle bit, reset to 0.
// - Bits 10 to 0 hold the read-only received code, reset to all zeros.
// - Expansion bits 15 to 5 ignore writes and always read as zero.
// - Expansion bit 4 is the read-only parallel detection fault flag, reset to 0.
// - Expansion bit 3 is the read-only partner next page ability, reset to 0.
// - Expansion bit 2 is a constant 1 showing the local end can send more pages.
// - Expansion bit 1 is set when a page is received and is cleared by reading the register, unless a page is accepted in the same cycle.
// - Expansion bit 0 is the read-only partner negotiation ability, reset to 0.
// - Bit 15 of the received page word shows whether the partner wants further pages.
// - Bit 14 is driven only from received bursts and software writes to it have no effect.
module autoneg_next_page_status_regs #(
    parameter int DW = negotiation_status_pkg::DATA_W,
    parameter int AW = negotiation_status_pkg::ADDR_W
) (
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,

    // Management register port
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [DW-1:0] rdata_o,

    // Arbitration side, same clock
    input wire logic page_accept_i,
    input wire logic [15:0] page_word_i,
    input wire logic partner_multi_page_capable_i,

    // Line detection levels, asynchronous
    input wire logic parallel_detect_fault_i,
    input wire logic partner_negotiation_capable_i,

    // Status towards the rest of the device
    output logic page_received_o,
    output logic partner_wants_more_pages_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [15:0] page_word_reg;
    logic page_rx_reg;
    logic partner_multi_reg;
    logic partner_multi_prev_reg;
    logic fault_prev_reg;
    logic [negotiation_status_pkg::EVT_W-1:0] evt_mask_reg;
    logic [15:0] page_count_reg;
    logic [DW-1:0] rdata_reg;
    logic page_rx_out_reg;
    logic more_pages_out_reg;

    logic [1:0] line_level;
    logic fault_level;
    logic partner_neg_level;

    logic hit_page_word;
    logic hit_expansion;
    logic hit_evt_status;
    logic hit_evt_mask;
    logic hit_page_count;

    logic exp_read;
    logic [15:0] expansion_value;
    logic [negotiation_status_pkg::EVT_W-1:0] evt_set;
    logic [negotiation_status_pkg::EVT_W-1:0] evt_clr;
    logic [negotiation_status_pkg::EVT_W-1:0] evt_status;
    logic [DW-1:0] read_mux;

    ////////////////////////////////////////////////////////////////////////////
    // Line detection levels arrive from the analogue front end, so they are
    // filtered before anything on this clock looks at them.

    pin_sync #(
        .W(2)
    ) u_line_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i({parallel_detect_fault_i, partner_negotiation_capable_i}),
        .level_o(line_level)
    );

    assign fault_level = line_level[1];
    assign partner_neg_level = line_level[0];

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    assign hit_page_word = (addr_i == AW'(negotiation_status_pkg::OFS_PAGE_WORD));
    assign hit_expansion = (addr_i == AW'(negotiation_status_pkg::OFS_EXPANSION));
    assign hit_evt_status = (addr_i == AW'(negotiation_status_pkg::OFS_EVT_STATUS));
    assign hit_evt_mask = (addr_i == AW'(negotiation_status_pkg::OFS_EVT_MASK));
    assign hit_page_count = (addr_i == AW'(negotiation_status_pkg::OFS_PAGE_COUNT));

    assign exp_read = re_i && hit_expansion;

    ////////////////////////////////////////////////////////////////////////////
    // Received next page word. There is deliberately no write path: every
    // bit, including the partner acknowledge, follows the accepted page only.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_word_reg <= negotiation_status_pkg::PAGE_WORD_RST;
        end else if (ce_i && page_accept_i) begin
            page_word_reg <= page_word_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page received flag. A page accepted in the same cycle as a read keeps
    // the flag set, so software sees the new page on its next read.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_rx_reg <= 1'b0;
        end else if (ce_i) begin
            if (page_accept_i) begin
                page_rx_reg <= 1'b1;
            end else if (exp_read) begin
                page_rx_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Partner next page ability, held from the arbitration logic.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            partner_multi_reg <= 1'b0;
        end else if (ce_i) begin
            partner_multi_reg <= partner_multi_page_capable_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Previous levels for edge events.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_prev_reg <= 1'b0;
            partner_multi_prev_reg <= 1'b0;
        end else if (ce_i) begin
            fault_prev_reg <= fault_level;
            partner_multi_prev_reg <= partner_multi_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Expansion register value.

    always_comb begin
        expansion_value = 16'h0000;
        expansion_value[negotiation_status_pkg::EXP_RSVD_MSB:negotiation_status_pkg::EXP_RSVD_LSB] = '0;
        expansion_value[negotiation_status_pkg::BIT_FAULT] = fault_level;
        expansion_value[negotiation_status_pkg::BIT_PARTNER_MULTI] = partner_multi_reg;
        expansion_value[negotiation_status_pkg::BIT_LOCAL_MULTI] = negotiation_status_pkg::LOCAL_MULTI_VALUE;
        expansion_value[negotiation_status_pkg::BIT_PAGE_RX] = page_rx_reg;
        expansion_value[negotiation_status_pkg::BIT_PARTNER_NEG] = partner_neg_level;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events. An overrun is a page that lands while the previous one has not
    // been read yet; the older word is lost, and software can tell.

    always_comb begin
        evt_set = '0;
        evt_set[negotiation_status_pkg::EVT_PAGE] = page_accept_i;
        evt_set[negotiation_status_pkg::EVT_FAULT] = fault_level && !fault_prev_reg;
        evt_set[negotiation_status_pkg::EVT_OVERRUN] = page_accept_i && page_rx_reg && !exp_read;
        evt_set[negotiation_status_pkg::EVT_PARTNER_MULTI] = partner_multi_reg && !partner_multi_prev_reg;
    end

    always_comb begin
        evt_clr = '0;
        if (we_i && hit_evt_status) begin
            evt_clr = wdata_i[negotiation_status_pkg::EVT_W-1:0];
        end
    end

    event_bank #(
        .W(negotiation_status_pkg::EVT_W)
    ) u_events (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(evt_set),
        .clr_i(evt_clr),
        .mask_i(evt_mask_reg),
        .status_o(evt_status),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event mask, written by software.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            evt_mask_reg <= negotiation_status_pkg::EVT_MASK_RST;
        end else if (ce_i && we_i && hit_evt_mask) begin
            evt_mask_reg <= wdata_i[negotiation_status_pkg::EVT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page counter. It saturates rather than wraps so a long exchange never
    // looks shorter than it was. A write to its own offset clears it, but a page accepted in
    // the same cycle still counts.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_count_reg <= negotiation_status_pkg::PAGE_COUNT_RST;
        end else if (ce_i) begin
            if (we_i && hit_page_count) begin
                page_count_reg <= page_accept_i ? 16'h0001 : 16'h0000;
            end else if (page_accept_i && (page_count_reg != 16'hffff)) begin
                page_count_reg <= page_count_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer. Unmapped offsets read as zero.

    always_comb begin
        read_mux = '0;
        if (hit_page_word) begin
            read_mux[negotiation_status_pkg::BIT_MORE_PAGES] =
                page_word_reg[negotiation_status_pkg::BIT_MORE_PAGES];
            read_mux[negotiation_status_pkg::BIT_PARTNER_ACK] =
                page_word_reg[negotiation_status_pkg::BIT_PARTNER_ACK];
            read_mux[negotiation_status_pkg::BIT_MSG_PAGE] =
                page_word_reg[negotiation_status_pkg::BIT_MSG_PAGE];
            read_mux[negotiation_status_pkg::BIT_COMPLY] =
                page_word_reg[negotiation_status_pkg::BIT_COMPLY];
            read_mux[negotiation_status_pkg::BIT_TOGGLE] =
                page_word_reg[negotiation_status_pkg::BIT_TOGGLE];
            read_mux[negotiation_status_pkg::CODE_MSB:negotiation_status_pkg::CODE_LSB] =
                page_word_reg[negotiation_status_pkg::CODE_MSB:negotiation_status_pkg::CODE_LSB];
        end else if (hit_expansion) begin
            read_mux[15:0] = expansion_value;
        end else if (hit_evt_status) begin
            read_mux[negotiation_status_pkg::EVT_W-1:0] = evt_status;
        end else if (hit_evt_mask) begin
            read_mux[negotiation_status_pkg::EVT_W-1:0] = evt_mask_reg;
        end else if (hit_page_count) begin
            read_mux[15:0] = page_count_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe, zero otherwise.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (ce_i) begin
            rdata_reg <= re_i ? read_mux : '0;
        end
    end

    assign rdata_o = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Registered status copies for the rest of the device.

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page_rx_out_reg <= 1'b0;
            more_pages_out_reg <= 1'b0;
        end else if (ce_i) begin
            page_rx_out_reg <= page_rx_reg;
            more_pages_out_reg <= page_word_reg[negotiation_status_pkg::BIT_MORE_PAGES];
        end
    end

    assign page_received_o = page_rx_out_reg;
    assign partner_wants_more_pages_o = more_pages_out_reg;

endmodule : autoneg_next_page_status_regs

// [verification/autoneg_status_assertions.sv]
// Concurrent checks on the ports of the next page status register bank.
`timescale 1ns/10ps
module autoneg_status_assertions #(
    parameter int DW = 16,
    parameter int AW = 4
) (
    // Clock, reset and clock enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Management register port
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    input wire logic [DW-1:0] rdata_o,
    // Arbitration and line side
    input wire logic page_accept_i,
    input wire logic [15:0] page_word_i,
    input wire logic partner_multi_page_capable_i,
    input wire logic parallel_detect_fault_i,
    input wire logic partner_negotiation_capable_i,
    // Status outputs
    input wire logic page_received_o,
    input wire logic partner_wants_more_pages_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // The line levels pass a synchroniser, so they are only compared once they have been steady a while.
    logic [15:0] word_q;
    logic [2:0] lvl_q;
    logic [2:0] settle_q;
    wire logic [2:0] lvl_now = {parallel_detect_fault_i, partner_multi_page_capable_i, partner_negotiation_capable_i};

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_q <= 16'h0000;
        end else if (ce_i && page_accept_i) begin
            word_q <= page_word_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_q <= 3'h0;
            settle_q <= 3'h0;
        end else begin
            lvl_q <= lvl_now;
            if (!ce_i || lvl_now != lvl_q) begin
                settle_q <= 3'h0;
            end else if (settle_q != 3'h7) begin
                settle_q <= settle_q + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_accept;
        ce_i && page_accept_i;
    endsequence
    sequence s_read_exp;
        ce_i && re_i && addr_i == negotiation_status_pkg::OFS_EXPANSION;
    endsequence
    sequence s_settled_read;
        s_read_exp ##0 settle_q >= 3'h6;
    endsequence

    a_word_readback: assert property (
        ce_i && re_i && addr_i == negotiation_status_pkg::OFS_PAGE_WORD && !page_accept_i |=> rdata_o == word_q)
        else $error("page word read differs from last accepted word");
    a_rsvd_read_zero: assert property (
        s_read_exp |=> rdata_o[15:5] == 11'h000)
        else $error("expansion upper bits not zero");
    a_local_multi_set: assert property (
        s_read_exp |=> rdata_o[2])
        else $error("local multi page bit not one");
    a_line_levels: assert property (
        s_settled_read |=> rdata_o[4] == $past(parallel_detect_fault_i) && rdata_o[3] ==
        $past(partner_multi_page_capable_i) && rdata_o[0] == $past(partner_negotiation_capable_i))
        else $error("expansion level bits differ from line levels");
    a_flag_after_accept: assert property (
        s_accept |-> ##2 page_received_o)
        else $error("page received flag not set after accept");
    a_read_clears_flag: assert property (
        s_read_exp ##0 !page_accept_i ##1 ce_i |=> !page_received_o)
        else $error("page received flag not cleared by read");
    a_flag_readback: assert property (
        s_read_exp ##0 !$past(page_accept_i) && !$past(re_i && addr_i == negotiation_status_pkg::OFS_EXPANSION)
        |=> rdata_o[1] == $past(page_received_o))
        else $error("read page received bit differs from flag");
    a_more_pages_out: assert property (
        s_accept |-> ##2 partner_wants_more_pages_o == $past(page_word_i[15], 2))
        else $error("more pages output differs from word bit 15");
endmodule : autoneg_status_assertions

bind autoneg_next_page_status_regs autoneg_status_assertions #(.DW(DW), .AW(AW)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
    .rdata_o(rdata_o), .page_accept_i(page_accept_i), .page_word_i(page_word_i),
    .partner_multi_page_capable_i(partner_multi_page_capable_i), .parallel_detect_fault_i(parallel_detect_fault_i),
    .partner_negotiation_capable_i(partner_negotiation_capable_i), .page_received_o(page_received_o),
    .partner_wants_more_pages_o(partner_wants_more_pages_o), .irq_o(irq_o)
);

// [verification/link_partner_model.sv]
// Behavioural link partner: hands over accepted pages and drives the line levels.
`timescale 1ns/10ps
module link_partner_model (
    // Clock
    input wire logic clk_i,
    // Page handover
    output logic page_accept_o,
    output logic [15:0] page_word_o,
    // Line levels
    output logic fault_o,
    output logic multi_page_o,
    output logic neg_capable_o
);
    initial begin
        page_accept_o = 1'b0;
        page_word_o = 16'h5555;
        {fault_o, multi_page_o, neg_capable_o} = 3'h0;
    end

    // The word is inverted after its accept cycle, so late sampling shows up as a wrong value.
    task automatic send_page(input logic [15:0] w);
        @(posedge clk_i);
        page_word_o <= w;
        page_accept_o <= 1'b1;
        @(posedge clk_i);
        page_accept_o <= 1'b0;
        page_word_o <= ~w;
    endtask : send_page

    // Levels are {fault, partner multi-page, partner negotiation}.
    task automatic set_levels(input logic [2:0] l);
        @(posedge clk_i);
        {fault_o, multi_page_o, neg_capable_o} <= l;
    endtask : set_levels
endmodule : link_partner_model

// [verification/test_autoneg_next_page_status_regs.sv]
// Self-checking bench for the next page status register bank.
`timescale 1ns/10ps
`define CHECK_EQ(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end

module test_autoneg_next_page_status_regs;
    typedef struct packed {
        logic [15:0] word;
        logic [2:0] lvl;
        logic [15:0] exp;
    } row_t;
    // Each row: page word, line levels, expected expansion value right after the page.
    row_t rows [4] = '{'{16'h2abc, 3'h0, 16'h0006}, '{16'h97ff, 3'h7, 16'h001f},
                       '{16'h4801, 3'h5, 16'h0017}, '{16'hd000, 3'h2, 16'h000e}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [15:0] rdata_o;
    logic page_accept_i, multi_i, fault_i, neg_i;
    logic [15:0] page_word_i;
    logic page_received_o, partner_wants_more_pages_o, irq_o;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    link_partner_model lp_u (.clk_i(clk_i), .page_accept_o(page_accept_i), .page_word_o(page_word_i),
        .fault_o(fault_i), .multi_page_o(multi_i), .neg_capable_o(neg_i));

    autoneg_next_page_status_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .page_accept_i(page_accept_i),
        .page_word_i(page_word_i), .partner_multi_page_capable_i(multi_i), .parallel_detect_fault_i(fault_i),
        .partner_negotiation_capable_i(neg_i), .page_received_o(page_received_o),
        .partner_wants_more_pages_o(partner_wants_more_pages_o), .irq_o(irq_o));

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : test_done

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(negedge clk_i);
        `CHECK_EQ(rdata_o, e)
    endtask : rd_chk

    task automatic irq_chk(input logic e);
        @(posedge clk_i);
        @(negedge clk_i);
        `CHECK_EQ(irq_o, e)
    endtask : irq_chk

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            lp_u.set_levels(rows[i].lvl);
            repeat (4) @(posedge clk_i);
            lp_u.send_page(rows[i].word);
            rd_chk(negotiation_status_pkg::OFS_PAGE_WORD, rows[i].word);
            `CHECK_EQ(partner_wants_more_pages_o, rows[i].word[15])
            rd_chk(negotiation_status_pkg::OFS_EXPANSION, rows[i].exp);
            rd_chk(negotiation_status_pkg::OFS_EXPANSION, rows[i].exp & 16'hfffd);
            $display("row %0d finished", i);
        end
        bus_wr(negotiation_status_pkg::OFS_PAGE_WORD, 16'hffff);
        bus_wr(negotiation_status_pkg::OFS_EXPANSION, 16'hffff);
        bus_wr(4'hf, 16'hffff);
        rd_chk(negotiation_status_pkg::OFS_PAGE_WORD, 16'hd000);
        rd_chk(negotiation_status_pkg::OFS_EXPANSION, 16'h000c);
        rd_chk(4'hf, 16'h0000);
        $display("write protection test finished");
        bus_wr(negotiation_status_pkg::OFS_EVT_MASK, 16'h0001);
        irq_chk(1'b1);
        rd_chk(negotiation_status_pkg::OFS_EVT_STATUS, 16'h000b);
        bus_wr(negotiation_status_pkg::OFS_EVT_STATUS, 16'h0001);
        irq_chk(1'b0);
        rd_chk(negotiation_status_pkg::OFS_EVT_STATUS, 16'h000a);
        $display("interrupt test finished");
        lp_u.send_page(16'h1234);
        lp_u.send_page(16'h8765);
        irq_chk(1'b1);
        rd_chk(negotiation_status_pkg::OFS_PAGE_WORD, 16'h8765);
        `CHECK_EQ(partner_wants_more_pages_o, 1'b1)
        rd_chk(negotiation_status_pkg::OFS_EVT_STATUS, 16'h000f);
        rd_chk(negotiation_status_pkg::OFS_EXPANSION, 16'h000e);
        $display("back to back page test finished");
        rd_chk(negotiation_status_pkg::OFS_PAGE_COUNT, 16'h0006);
        @(posedge clk_i);
        ce_i <= 1'b0;
        lp_u.send_page(16'h0f0f);
        ce_i <= 1'b1;
        rd_chk(negotiation_status_pkg::OFS_PAGE_WORD, 16'h8765);
        rd_chk(negotiation_status_pkg::OFS_EXPANSION, 16'h000c);
        rd_chk(negotiation_status_pkg::OFS_PAGE_COUNT, 16'h0006);
        bus_wr(negotiation_status_pkg::OFS_PAGE_COUNT, 16'h0000);
        rd_chk(negotiation_status_pkg::OFS_PAGE_COUNT, 16'h0000);
        $display("clock enable and counter test finished");
        lp_u.set_levels(3'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(negedge clk_i);
        `CHECK_EQ({page_received_o, partner_wants_more_pages_o, irq_o}, 3'h0)
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(negotiation_status_pkg::OFS_PAGE_WORD, 16'h0000);
        rd_chk(negotiation_status_pkg::OFS_EXPANSION, 16'h0004);
        rd_chk(negotiation_status_pkg::OFS_EVT_STATUS, 16'h0000);
        $display("reset test finished");
        test_done();
    end
endmodule : test_autoneg_next_page_status_regs
